// file: logic/adcseq_defs.vh
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH

// Register byte offsets on the Avalon-MM slave
`define ADCSEQ_REG_CTRL0 5'h00
`define ADCSEQ_REG_CTRL1 5'h04
`define ADCSEQ_REG_STATUS 5'h08
`define ADCSEQ_REG_RESULT 5'h0c
`define ADCSEQ_REG_CMP 5'h10
`define ADCSEQ_REG_ANCFG 5'h14
`define ADCSEQ_REG_PORTIN 5'h18
`define ADCSEQ_REG_OFFSET 5'h1c

// Control register 0 fields
`define ADCSEQ_C0_EN 0
`define ADCSEQ_C0_GO 1
`define ADCSEQ_C0_CHS_LSB 2

// Control register 1 fields
`define ADCSEQ_C1_CS_LSB 0
`define ADCSEQ_C1_ACQ_LSB 3
`define ADCSEQ_C1_CAL 6
`define ADCSEQ_C1_FMT 7

// Status register fields
`define ADCSEQ_ST_DONE 0
`define ADCSEQ_ST_CALOK 1

// Reset values
`define ADCSEQ_CTRL1_RST 8'h00
`define ADCSEQ_CHS_RST 4'h0
`define ADCSEQ_CMP_RST 4'h0
`define ADCSEQ_ANCFG_RST 16'h0000
`define ADCSEQ_RESULT_RST 16'h0000
`define ADCSEQ_OFFSET_RST 10'h000

// Compare mode that routes the special event trigger to the converter
`define ADCSEQ_CMP_SPECIAL 4'hb

// Timing
`define ADCSEQ_MCLK_PERIOD_NS 50
`define ADCSEQ_INSTR_NS 200
`define ADCSEQ_CONV_TADS 5'd11
`define ADCSEQ_RECOVER_TADS 5'd2

`endif

// file: logic/adcseq_tad_gen.v
`timescale 1ns/1ps
`default_nettype none

// Bit-period enable generator: divided mclk or the RC oscillator tick
module adcseq_tad_gen (
  input wire mclk,
  input wire sys_rst,
  input wire [2:0] clk_sel,
  input wire rc_tick,
  input wire sync_clr,
  output reg tad_tick
);

  reg [5:0] div_q;
  reg [5:0] div_d;
  reg [5:0] last;
  reg use_rc;

  // bit period select
  // Divide ratio decode, x11 picks the RC source
  always @* begin
    use_rc = (clk_sel[1:0] == 2'b11);
    case (clk_sel)
      3'b000: last = 6'h01;
      3'b100: last = 6'h03;
      3'b001: last = 6'h07;
      3'b101: last = 6'h0f;
      3'b010: last = 6'h1f;
      3'b110: last = 6'h3f;
      default: last = 6'h01;
    endcase
    div_d = (div_q == last) ? 6'h00 : div_q + 6'h01;
  end

  // Restart on sync_clr so a divided first bit period is full length;
  // the RC source runs free, so its first period may come short
  always @(posedge mclk) begin
    if (sys_rst) begin
      div_q <= 6'h00;
      tad_tick <= 1'b0;
    end else if (sync_clr) begin
      div_q <= 6'h00;
      tad_tick <= use_rc & rc_tick;
    end else begin
      div_q <= div_d;
      // Tick set one edge early so it stands in the wrap cycle
      tad_tick <= use_rc ? rc_tick : (div_d == last);
    end
  end

endmodule // adcseq_tad_gen

`default_nettype wire

// file: logic/adcseq_top.v
// Operation
// - Acquisition code 000: go stops sampling and starts conversion, no auto acquisition.
// - Nonzero acquisition code: keep sampling programmed bit periods, then convert.
// - Acquisition code 010 gives four bit periods before conversion.
// - Completion clears go, sets done flag, resumes sampling.
// - No status separates acquisition from conversion; go stays set throughout.
// - A conversion lasts exactly eleven bit periods, except on RC from acquisition code 000.
// - Clock select picks 2,4,8,16,32,64 oscillator periods or RC for x11.
// - Port input reads zero on pins configured analog.
// - Conversion start disconnects the holding capacitor from the pin.
// - Code 000: conversion begins one instruction after go is set.
// - Clearing go mid-conversion aborts it; no partial result written.
// - After abort the result keeps last completed or written value.
// - After completion or abort wait two bit periods, then sample again.
// - Special event trigger sets go when compare mode 1011 and enabled.
// - Each special event trigger in compare mode 1011 resets the associated timer counter.
// - With converter disabled trigger is ignored but timer still resets.
// - Calibrate request makes the next go a dummy offset conversion.
// - Stored offset corrects every later conversion.
// - Acquisition codes give 0,2,4,6,8,12,16,20 bit periods.
// - Result loads together with go clear and done flag set.
// - Justify bit: 1 right justified, 0 left justified.
// - Reset switches the converter off and aborts any conversion.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.vh"

module adcseq_top (
  input wire mclk,
  input wire sys_rst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire rc_osc_tick,
  input wire special_event_trig,
  input wire [15:0] port_pins_in,
  input wire [9:0] adc_raw_data,
  output reg sample_connect,
  output reg calib_select,
  output reg conv_active,
  output reg trigger_timer_reset,
  output reg [3:0] channel_select,
  output reg conversion_done_irq_flag
);

  // Sequencer states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DELAY = 3'd1;
  localparam [2:0] ST_ACQ = 3'd2;
  localparam [2:0] ST_CONV = 3'd3;
  localparam [2:0] ST_RECOVER = 3'd4;

  // One instruction cycle in mclk cycles, rounded up
  localparam integer INSTR_CYC_I = (`ADCSEQ_INSTR_NS + `ADCSEQ_MCLK_PERIOD_NS - 1) / `ADCSEQ_MCLK_PERIOD_NS;
  localparam [2:0] INSTR_CYC = INSTR_CYC_I[2:0];

  // acquisition code table
  // Acquisition length in bit periods
  function [4:0] acq_tads;
    input [2:0] code;
    begin
      case (code)
        3'b000: acq_tads = 5'd0;
        3'b001: acq_tads = 5'd2;
        3'b010: acq_tads = 5'd4;
        3'b011: acq_tads = 5'd6;
        3'b100: acq_tads = 5'd8;
        3'b101: acq_tads = 5'd12;
        3'b110: acq_tads = 5'd16;
        default: acq_tads = 5'd20;
      endcase
    end
  endfunction

  // Word address match
  function hit;
    input [4:0] addr;
    input [4:0] off;
    begin
      hit = (addr[4:2] == off[4:2]);
    end
  endfunction

  reg ack_q;
  reg en_q;
  reg go_q;
  reg go_d;
  reg [7:0] ctrl1_q;
  reg [3:0] cmp_q;
  reg [15:0] ancfg_q;
  reg [15:0] result_q;
  reg [9:0] offset_q;
  reg calok_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [4:0] cnt_q;
  reg [4:0] cnt_d;
  reg [2:0] dly_q;
  reg [2:0] dly_d;
  reg cal_run_q;
  reg [9:0] corrected;
  reg done_set;
  reg start;
  reg en_d;
  reg [31:0] rd_mux;
  wire tad_tick;
  wire wr_fire;
  wire rd_take;
  wire [4:0] acq_len;
  wire trig_ok;
  wire busy;

  // One wait state: request taken on first edge, answered on second
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_fire = avs_write & ack_q;
  assign rd_take = avs_read & ~ack_q;
  assign acq_len = acq_tads(ctrl1_q[`ADCSEQ_C1_ACQ_LSB +: 3]);
  assign busy = (state_q == ST_DELAY) || (state_q == ST_ACQ) || (state_q == ST_CONV);

  assign trig_ok = special_event_trig && en_q && (cmp_q == `ADCSEQ_CMP_SPECIAL);

  adcseq_tad_gen u_tad (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_sel(ctrl1_q[`ADCSEQ_C1_CS_LSB +: 3]),
    .rc_tick(rc_osc_tick),
    .sync_clr(start),
    .tad_tick(tad_tick)
  );

  // Bus acknowledge toggles every request cycle
  always @(posedge mclk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Enable and go flag next values
  always @* begin
    en_d = en_q;
    go_d = go_q;
    if (wr_fire && hit(avs_address, `ADCSEQ_REG_CTRL0) && avs_byteenable[0]) begin
      en_d = avs_writedata[`ADCSEQ_C0_EN];
      // go only honoured once already enabled
      go_d = avs_writedata[`ADCSEQ_C0_GO] & en_q;
    end
    if (done_set) begin
      go_d = 1'b0;
    end
    if (trig_ok) begin
      go_d = 1'b1;
    end
    if (!en_d) begin
      go_d = 1'b0;
    end
  end

  // Result after offset correction, floored at zero
  always @* begin
    if (adc_raw_data > offset_q) begin
      corrected = adc_raw_data - offset_q;
    end else begin
      corrected = 10'h000;
    end
  end

  // Sequencer next state
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    dly_d = dly_q;
    done_set = 1'b0;
    start = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 5'd0;
        dly_d = 3'd0;
        if (go_q && en_q) begin
          start = 1'b1;
          if (acq_len == 5'd0) begin
            state_d = ST_DELAY;
          end else begin
            state_d = ST_ACQ;
          end
        end
      end
      ST_DELAY: begin
        dly_d = dly_q + 3'd1;
        if (dly_q == INSTR_CYC - 3'd1) begin
          state_d = ST_CONV;
          start = 1'b1;
          dly_d = 3'd0;
        end
      end
      ST_ACQ: begin
        if (tad_tick) begin
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == acq_len - 5'd1) begin
            state_d = ST_CONV;
            cnt_d = 5'd0;
          end
        end
      end
      ST_CONV: begin
        if (tad_tick) begin
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == `ADCSEQ_CONV_TADS - 5'd1) begin
            done_set = 1'b1;
            state_d = ST_RECOVER;
            cnt_d = 5'd0;
          end
        end
      end
      ST_RECOVER: begin
        if (tad_tick) begin
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == `ADCSEQ_RECOVER_TADS - 5'd1) begin
            state_d = ST_IDLE;
            cnt_d = 5'd0;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 5'd0;
      end
    endcase
    if (busy && !go_q) begin
      state_d = ST_RECOVER;
      cnt_d = 5'd0;
      done_set = 1'b0;
      start = 1'b1;
    end
    if (!en_q) begin
      state_d = ST_IDLE;
      cnt_d = 5'd0;
      done_set = 1'b0;
    end
  end

  // Sequencer and flag registers
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'd0;
      dly_q <= 3'd0;
      en_q <= 1'b0;
      go_q <= 1'b0;
      cal_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dly_q <= dly_d;
      en_q <= en_d;
      go_q <= go_d;
      if (state_q == ST_IDLE && state_d != ST_IDLE) begin
        cal_run_q <= ctrl1_q[`ADCSEQ_C1_CAL];
      end
    end
  end

  // Software registers, result and offset
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl1_q <= `ADCSEQ_CTRL1_RST;
      channel_select <= `ADCSEQ_CHS_RST;
      cmp_q <= `ADCSEQ_CMP_RST;
      ancfg_q <= `ADCSEQ_ANCFG_RST;
      result_q <= `ADCSEQ_RESULT_RST;
      offset_q <= `ADCSEQ_OFFSET_RST;
      calok_q <= 1'b0;
      conversion_done_irq_flag <= 1'b0;
    end else begin
      if (wr_fire && avs_byteenable[0]) begin
        if (hit(avs_address, `ADCSEQ_REG_CTRL0)) begin
          channel_select <= avs_writedata[`ADCSEQ_C0_CHS_LSB +: 4];
        end
        if (hit(avs_address, `ADCSEQ_REG_CTRL1)) begin
          ctrl1_q <= avs_writedata[7:0];
        end
        if (hit(avs_address, `ADCSEQ_REG_CMP)) begin
          cmp_q <= avs_writedata[3:0];
        end
        if (hit(avs_address, `ADCSEQ_REG_STATUS) && avs_writedata[`ADCSEQ_ST_DONE]) begin
          conversion_done_irq_flag <= 1'b0;
        end
      end
      if (wr_fire && hit(avs_address, `ADCSEQ_REG_ANCFG)) begin
        if (avs_byteenable[0]) begin
          ancfg_q[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          ancfg_q[15:8] <= avs_writedata[15:8];
        end
      end
      if (wr_fire && hit(avs_address, `ADCSEQ_REG_RESULT)) begin
        if (avs_byteenable[0]) begin
          result_q[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          result_q[15:8] <= avs_writedata[15:8];
        end
      end
      if (done_set) begin
        // done flag set wins over clear
        conversion_done_irq_flag <= 1'b1;
        if (cal_run_q) begin
          offset_q <= adc_raw_data;
          calok_q <= 1'b1;
        end else if (ctrl1_q[`ADCSEQ_C1_FMT]) begin
          result_q <= {6'h00, corrected};
        end else begin
          result_q <= {corrected, 6'h00};
        end
      end
    end
  end

  // Analog front end controls and trigger pulse
  always @(posedge mclk) begin
    if (sys_rst) begin
      sample_connect <= 1'b1;
      calib_select <= 1'b0;
      conv_active <= 1'b0;
      trigger_timer_reset <= 1'b0;
    end else begin
      // capacitor off the pin from conversion to resume
      sample_connect <= (state_d == ST_IDLE) || (state_d == ST_ACQ) || (state_d == ST_DELAY);
      calib_select <= (state_d != ST_IDLE) && ((state_q == ST_IDLE) ? ctrl1_q[`ADCSEQ_C1_CAL] : cal_run_q);
      conv_active <= (state_d == ST_CONV);
      trigger_timer_reset <= special_event_trig && (cmp_q == `ADCSEQ_CMP_SPECIAL);
    end
  end

  // Read mux; go flag alone shows activity
  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address, `ADCSEQ_REG_CTRL0)) begin
      rd_mux[5:0] = {channel_select, go_q, en_q};
    end else if (hit(avs_address, `ADCSEQ_REG_CTRL1)) begin
      rd_mux[7:0] = ctrl1_q;
    end else if (hit(avs_address, `ADCSEQ_REG_STATUS)) begin
      rd_mux[1:0] = {calok_q, conversion_done_irq_flag};
    end else if (hit(avs_address, `ADCSEQ_REG_RESULT)) begin
      rd_mux[15:0] = result_q;
    end else if (hit(avs_address, `ADCSEQ_REG_CMP)) begin
      rd_mux[3:0] = cmp_q;
    end else if (hit(avs_address, `ADCSEQ_REG_ANCFG)) begin
      rd_mux[15:0] = ancfg_q;
    end else if (hit(avs_address, `ADCSEQ_REG_PORTIN)) begin
      rd_mux[15:0] = port_pins_in & ancfg_q;
    end else begin
      rd_mux[9:0] = offset_q;
    end
  end

  // Read data captured on the taking edge, stands at the answer edge
  always @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule // adcseq_top

`default_nettype wire

// file: verification/adcseq_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adcseq_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic special_event_trig,
  input wire logic sample_connect,
  input wire logic conv_active,
  input wire logic trigger_timer_reset,
  input wire logic conversion_done_irq_flag
);
  logic en_q;
  logic cmp_q;
  logic [9:0] cv_q;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire w1c_done = wr_ok && avs_address[4:2] == 3'h2 && avs_writedata[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Shadow of enable and compare mode, taken at the write edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_q <= 1'b0;
      cmp_q <= 1'b0;
    end else if (wr_ok && avs_address[4:2] == 3'h0) begin
      en_q <= avs_writedata[0];
    end else if (wr_ok && avs_address[4:2] == 3'h4) begin
      cmp_q <= avs_writedata[3:0] == 4'hb;
    end
  end
  // Length of the running conversion; ten bits cover 11 x 64
  always_ff @(posedge mclk) begin
    if (sys_rst || !conv_active)
      cv_q <= 10'h000;
    else
      cv_q <= cv_q + 10'h001;
  end
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_recover;
    !sample_connect [*3];
  endsequence
  a_bus_one_wait: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
    else $error("bus wait state");
  a_conv_disc: assert property (conv_active |-> !sample_connect)
    else $error("cap connected in conversion");
  a_done_after: assert property ($rose(conversion_done_irq_flag) |-> $past(conv_active))
    else $error("done without conversion");
  a_conv_len: assert property ($rose(conversion_done_irq_flag) |-> cv_q >= 10'h016)
    else $error("conversion too short");
  a_recover_low: assert property ($fell(conv_active) && en_q |-> s_recover)
    else $error("no recovery wait");
  a_off_idle: assert property ($fell(en_q) |-> ##[0:1] (sample_connect && !conv_active))
    else $error("disable did not idle");
  a_off_quiet: assert property (!en_q && !conv_active |=> !conv_active)
    else $error("conversion while off");
  a_trig_timer: assert property (special_event_trig && cmp_q |=> trigger_timer_reset)
    else $error("timer not reset");
  a_timer_cause: assert property (trigger_timer_reset |-> $past(special_event_trig))
    else $error("timer reset without trigger");
  a_trig_start: assert property (special_event_trig && cmp_q && en_q && !conv_active |-> ##[1:300] conv_active)
    else $error("trigger did not start");
  a_done_hold: assert property (conversion_done_irq_flag && !w1c_done |=> conversion_done_irq_flag)
    else $error("done flag lost");
endmodule // adcseq_chk
bind adcseq_top adcseq_chk u_chk (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .special_event_trig, .sample_connect, .conv_active,
  .trigger_timer_reset, .conversion_done_irq_flag);
`default_nettype wire

// file: verification/adcseq_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcseq_front_model #(
  parameter int RC_DIV = 3,
  parameter logic [9:0] CAL_RAW = 10'h008
) (
  input wire logic mclk,
  input wire logic sample_connect,
  input wire logic calib_select,
  input wire logic [3:0] channel_select,
  output logic rc_osc_tick,
  output logic [9:0] adc_raw_data
);
  int cnt = 0;
  logic [9:0] held_q = 10'h000;
  initial rc_osc_tick = 1'b0;
  // Free RC oscillator, one tick every RC_DIV cycles
  always @(posedge mclk) begin
    cnt <= (cnt == RC_DIV - 1) ? 0 : cnt + 1;
    rc_osc_tick <= (cnt == RC_DIV - 1);
  end
  // cap tracks the pin only while connected
  always @(posedge mclk) begin
    if (sample_connect)
      held_q <= {channel_select, 6'h15};
  end
  // dummy run sees only the internal offset
  assign adc_raw_data = calib_select ? CAL_RAW : held_q;
endmodule // adcseq_front_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [2:0] cs;
    logic [2:0] aq;
    logic fm;
    logic [3:0] ch;
    logic [6:0] tad;
    logic [4:0] na;
    logic [15:0] res;
  } adcseq_row_t;
  // every clock setting is swept; model has no minimum bit period or Sleep
  // Clock, acquisition, format, channel; bit period, periods acquired, result
  adcseq_row_t rows [10] = '{
    '{3'h0, 3'h0, 1'h1, 4'h3, 7'h02, 5'h00, 16'h00d5},
    '{3'h4, 3'h1, 1'h0, 4'h5, 7'h04, 5'h02, 16'h5540},
    '{3'h1, 3'h2, 1'h1, 4'h7, 7'h08, 5'h04, 16'h01d5},
    '{3'h5, 3'h3, 1'h0, 4'h1, 7'h10, 5'h06, 16'h1540},
    '{3'h2, 3'h4, 1'h1, 4'h2, 7'h20, 5'h08, 16'h0095},
    '{3'h6, 3'h5, 1'h0, 4'h4, 7'h40, 5'h0c, 16'h4540},
    '{3'h0, 3'h6, 1'h1, 4'h9, 7'h02, 5'h10, 16'h0255},
    '{3'h4, 3'h7, 1'h0, 4'hf, 7'h04, 5'h14, 16'hf540},
    '{3'h3, 3'h0, 1'h1, 4'h6, 7'h03, 5'h00, 16'h0195},
    '{3'h7, 3'h1, 1'h0, 4'h8, 7'h03, 5'h02, 16'h8540}};
  logic [4:0] ra [5] = '{5'h00, 5'h04, 5'h0c, 5'h1c, 5'h18};
  logic mclk, sys_rst, avs_read, avs_write, special_event_trig, rc_osc_tick, avs_waitrequest;
  logic sample_connect, calib_select, conv_active, trigger_timer_reset, conversion_done_irq_flag;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv, e, a;
  logic [3:0] avs_byteenable, channel_select;
  logic [15:0] port_pins_in = 16'ha5c3;
  logic [9:0] adc_raw_data;
  logic cv_q = 1'b0, sc_q = 1'b0, cal_seen = 1'b0;
  time t_cs, t_ce, t_sr, t_go;
  adcseq_row_t r;
  int miscompares = 0, n_checks = 0, n_trr = 0, k;
  adcseq_top dut (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .rc_osc_tick, .special_event_trig, .port_pins_in, .adc_raw_data,
    .sample_connect, .calib_select, .conv_active, .trigger_timer_reset, .channel_select,
    .conversion_done_irq_flag);
  adcseq_front_model #(.RC_DIV(3), .CAL_RAW(10'h008)) u_fe (.mclk, .sample_connect, .calib_select,
    .channel_select, .rc_osc_tick, .adc_raw_data);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Phase stamps at the falling edge, where outputs are settled
  always @(negedge mclk) begin
    cv_q <= conv_active;
    sc_q <= sample_connect;
    if (conv_active === 1'b1 && !cv_q) t_cs <= $time;
    if (conv_active === 1'b0 && cv_q) t_ce <= $time;
    if (sample_connect === 1'b1 && !sc_q) t_sr <= $time;
    if (calib_select === 1'b1) cal_seen <= 1'b1;
    if (trigger_timer_reset === 1'b1) n_trr <= n_trr + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [4:0] ad, input logic [31:0] d);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    t_go = $time;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // channel and enable go in one write ahead of go
  task automatic go(input logic [3:0] c);
    acc(1'b1, 5'h00, {26'h0, c, 2'b01});
    acc(1'b1, 5'h00, {26'h0, c, 2'b11});
  endtask
  // Bounded poll: 0 done flag, 1 sampling, 2 converting
  task automatic wt(input int s);
    for (k = 0; k < 4000; k++) begin
      @(negedge mclk);
      if (s == 0 && conversion_done_irq_flag === 1'b1) break;
      if (s == 1 && sample_connect === 1'b1) break;
      if (s == 2 && conv_active === 1'b1) break;
    end
    chk(32'(k < 4000), 32'h1);
    @(posedge mclk);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Longest row takes under 2000 cycles; whole run well below this
  initial begin
    #(50 * 40000);
    miscompares++;
    finish_test;
  end
  initial begin
    {sys_rst, avs_read, avs_write, special_event_trig} = 4'h8;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    foreach (ra[j]) begin
      acc(1'b0, ra[j], 32'h0);
      chk(rdv, 32'h0);
    end
    acc(1'b1, 5'h14, 32'h00ff);
    acc(1'b0, 5'h18, 32'h0);
    chk(rdv, 32'h00c3);
    foreach (rows[i]) begin
      r = rows[i];
      acc(1'b1, 5'h04, {24'h0, r.fm, 1'b0, r.aq, r.cs});
      go(r.ch);
      e = 32'(t_go);
      acc(1'b0, 5'h00, 32'h0);
      chk(rdv[1], 1'b1);
      chk(channel_select, r.ch);
      wt(0);
      acc(1'b0, 5'h00, 32'h0);
      chk(rdv[1], 1'b0);
      acc(1'b0, 5'h0c, 32'h0);
      chk(rdv, r.res);
      wt(1);
      a = 32'((t_cs - e) / 50);
      e = (r.na != 0) ? r.na * r.tad : 32'h4;
      chk(32'(a + 2 >= e && a <= e + r.tad + 2), 32'h1);
      a = 32'((t_ce - t_cs) / 50);
      // Free RC ticks: only the first bit period may be cut short
      if (r.cs[1:0] == 2'b11) begin
        chk(32'(a > 10 * r.tad && a <= 11 * r.tad), 32'h1);
      end else begin
        chk(a, 11 * r.tad);
      end
      a = 32'((t_sr - t_ce) / 50);
      chk(32'(a + 1 >= 2 * r.tad && a <= 2 * r.tad + 2), 32'h1);
      acc(1'b1, 5'h08, 32'h1);
      $display("row %0d done", i);
    end
    // Abort keeps the value software wrote
    acc(1'b1, 5'h0c, 32'h1234);
    acc(1'b1, 5'h04, 32'h06);
    go(4'h2);
    wt(2);
    acc(1'b1, 5'h00, 32'h09);
    wt(1);
    acc(1'b0, 5'h0c, 32'h0);
    chk(rdv, 32'h1234);
    chk(32'((t_sr - t_ce) / 50) + 1 >= 128, 1'b1);
    acc(1'b0, 5'h08, 32'h0);
    chk(rdv[0], 1'b0);
    // Disable in mid conversion
    go(4'h2);
    wt(2);
    acc(1'b1, 5'h00, 32'h0);
    @(negedge mclk);
    chk({conv_active, sample_connect}, 2'b01);
    @(posedge mclk);
    $display("abort done");
    // offset run, then a corrected conversion
    acc(1'b1, 5'h04, 32'hc0);
    go(4'h3);
    wt(0);
    chk(cal_seen, 1'b1);
    acc(1'b0, 5'h1c, 32'h0);
    chk(rdv, 32'h008);
    acc(1'b0, 5'h08, 32'h0);
    chk(rdv[1:0], 2'b11);
    acc(1'b1, 5'h08, 32'h1);
    wt(1);
    acc(1'b1, 5'h04, 32'h80);
    go(4'h3);
    wt(0);
    acc(1'b0, 5'h0c, 32'h0);
    chk(rdv, 32'h00cd);
    acc(1'b1, 5'h08, 32'h1);
    wt(1);
    $display("calibration done");
    // Trigger in another compare mode moves nothing
    special_event_trig <= 1'b1;
    @(posedge mclk);
    special_event_trig <= 1'b0;
    // Compare trigger while enabled, then while off
    acc(1'b1, 5'h10, 32'hb);
    special_event_trig <= 1'b1;
    @(posedge mclk);
    special_event_trig <= 1'b0;
    wt(0);
    acc(1'b1, 5'h08, 32'h1);
    wt(1);
    acc(1'b1, 5'h00, 32'h0);
    special_event_trig <= 1'b1;
    @(posedge mclk);
    special_event_trig <= 1'b0;
    repeat (40) @(posedge mclk);
    acc(1'b0, 5'h08, 32'h0);
    chk(rdv[0], 1'b0);
    chk(n_trr, 32'h2);
    $display("trigger done");
    // Reset in mid conversion
    go(4'h1);
    wt(2);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({conv_active, sample_connect, conversion_done_irq_flag}, 3'b010);
    @(posedge mclk);
    acc(1'b0, 5'h00, 32'h0);
    chk(rdv, 32'h0);
    $display("reset done");
    finish_test;
  end
endmodule // tb
`default_nettype wire
